/* dpfc_array_model.sv */
`timescale 1ns/1ps
module dpfc_array_model
  import dpfc_pkg::*;
#(
  parameter int unsigned DELAY = 3,
  parameter logic [15:0] RDATA = 16'h5A3C
) (
  // clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_b,
  // operation and stall control
  input  wire dpfc_pkg::dpfc_array_cmd_t i_cmd,
  input  wire logic                     i_hold,
  // answers
  output logic [15:0]                   o_rdata,
  output logic                          o_done
);
  logic [15:0] cnt_r;
  // a suspend drops start, so the count restarts on resume
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || !i_cmd.start || o_done) cnt_r <= 16'h0000;
    else if (!i_hold) cnt_r <= cnt_r + 16'h0001;
  end
  always_ff @(posedge i_core_clk) begin
    o_done <= i_rst_b && i_cmd.start && !o_done && !i_hold && cnt_r == 16'(DELAY - 1);
  end
  assign o_rdata = RDATA;
endmodule // dpfc_array_model

/* dpfc_defines.svh */
// Functional notes
// RULE1: outputs invalid until reset-to-output time elapses
// RULE2: command writes ignored until wake time elapses
// RULE3: single block erase and full-array erase
// RULE4: word program or page-buffer program
// RULE5: erase and program suspend, same-partition reads
// RULE6: nested suspend; program resumes before erase
// RULE7: reads elsewhere allow normal program/erase activity
// RULE8: OTP program/full erase: others status only
// RULE9: one busy partition; only page data queues
// RULE10: one status register per partition
// RULE11: host addresses commands inside target block
// RULE12: burst stops at partition boundary
// RULE13: data pins float when deselected or ungated
// RULE14: operation data held in internal latches
// RULE15: chip select high deselects control and inputs
// RULE16: burst address capture edge per config bit six
// RULE17: burst clock ignored in asynchronous mode
// RULE18: address width 21 or 22 bits
// RULE19: data pins carry commands in, mode data out
// RULE20: write captured on first rising strobe edge
// RULE21: reset leaves device in asynchronous array read
// RULE22: reset gives read array and status 80 hex
// RULE23: partition decoded from upper address bits
`ifndef DPFC_DEFINES_SVH
`define DPFC_DEFINES_SVH
`define DPFC_CLK_MHZ          125
`define DPFC_T_RST_OUT_NS     150
`define DPFC_T_RST_WR_NS      150
`define DPFC_RST_OUT_CYC      ((`DPFC_T_RST_OUT_NS * `DPFC_CLK_MHZ + 999) / 1000)
`define DPFC_RST_WR_CYC       ((`DPFC_T_RST_WR_NS * `DPFC_CLK_MHZ + 999) / 1000)
`define DPFC_ADDR_W           22
`define DPFC_STATUS_RESET     8'h80
`define DPFC_SR_READY         7
`define DPFC_SR_ERS_SUSP      6
`define DPFC_SR_PRG_SUSP      2
`define DPFC_CMD_READ_ARRAY   8'hFF
`define DPFC_CMD_READ_ID      8'h90
`define DPFC_CMD_READ_QUERY   8'h98
`define DPFC_CMD_READ_STATUS  8'h70
`define DPFC_CMD_CLR_STATUS   8'h50
`define DPFC_CMD_WORD_PROG    8'h40
`define DPFC_CMD_PAGE_PROG    8'hE8
`define DPFC_CMD_OTP_PROG     8'hC0
`define DPFC_CMD_BLK_ERASE    8'h20
`define DPFC_CMD_CHIP_ERASE   8'h30
`define DPFC_CMD_CONFIRM      8'hD0
`define DPFC_CMD_SUSPEND      8'hB0
`define DPFC_CMD_RESUME       8'hD0
`define DPFC_CMD_SET_RCR      8'h60
`define DPFC_CMD_RCR_CONFIRM  8'h03
`define DPFC_PAGE_WORDS       16
`define DPFC_PAGE_IDX_W       4
`define DPFC_RCR_SYNC_N       15
`define DPFC_RCR_CLK_EDGE     6
`define DPFC_PART_SHIFT       20
`define DPFC_BLK_SHIFT        15
`define DPFC_OP_CYCLES        16'h0040
`endif

/* dpfc_delay_cnt.sv */
`timescale 1ns/1ps
`include "dpfc_defines.svh"
// counts enabled cycles after reset release and then stays done
module dpfc_delay_cnt #(
  parameter int unsigned CYCLES = 1
) (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  // status
  output logic      o_done
);
  logic [15:0] cnt_r;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      cnt_r  <= 16'h0000;
      o_done <= 1'b0;
    end else if (i_ce && !o_done) begin
      cnt_r  <= cnt_r + 16'h0001;
      o_done <= (cnt_r + 16'h0001) >= 16'(CYCLES);
    end
  end
endmodule // dpfc_delay_cnt

/* dpfc_flash_ctrl.sv */
`timescale 1ns/1ps
`include "dpfc_defines.svh"
module dpfc_flash_ctrl
  import dpfc_pkg::*;
(
  // clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_ce,
  // bus pins, synchronous to the core clock
  input  wire logic                    i_chip_sel_n,
  input  wire logic                    i_out_gate_n,
  input  wire logic                    i_write_n,
  input  wire logic                    i_address_valid_n,
  input  wire logic                    i_burst_clk,
  input  wire logic                    i_big_variant,
  input  wire logic [`DPFC_ADDR_W-1:0] i_address_pins,
  input  wire logic [15:0]             i_data_pins,
  // data pin drive
  output logic [15:0]                  o_data_pins,
  output logic                         o_data_oe,
  // array side
  output dpfc_pkg::dpfc_array_cmd_t    o_array_cmd,
  input  wire logic [15:0]             i_array_rdata,
  input  wire logic                    i_array_done,
  output logic                         o_standby
);
  import dpfc_pkg::*;

  typedef enum logic [2:0] {
    DPFC_S_IDLE, DPFC_S_SETUP, DPFC_S_PAGE_CNT, DPFC_S_PAGE_DATA,
    DPFC_S_CONFIRM, DPFC_S_RCR
  } dpfc_cmd_st_t;

  logic                    out_ok, wr_ok;
  logic                    we_d_r, cs_d_r, adv_d_r, bclk_d_r;
  logic                    wr_edge;
  dpfc_wr_t                wr;
  logic [`DPFC_ADDR_W-1:0] amask;
  logic [1:0]              wpart;
  logic [1:0]              rpart;
  dpfc_cmd_st_t            cmd_st_r;
  dpfc_op_t                pend_op_r;
  dpfc_rmode_t             rmode_r [4];
  logic [15:0]             rcr_r;
  dpfc_op_t                act_op_r, susp_prg_op_r;
  logic [1:0]              act_part_r, ers_part_r, prg_part_r;
  logic                    busy_r, ers_susp_r, prg_susp_r;
  logic [`DPFC_ADDR_W-1:0] op_addr_r, ers_addr_r, prg_addr_r;
  logic [15:0]             op_data_r, prg_data_r;
  logic [15:0]             page_buf_r [`DPFC_PAGE_WORDS];
  logic [`DPFC_PAGE_IDX_W-1:0] page_cnt_r, page_idx_r;
  logic [7:0]              status [4];
  logic [3:0]              clr_st;
  logic                    exclusive;
  logic [`DPFC_ADDR_W-1:0] burst_addr_r;
  logic                    burst_on_r;
  logic                    bclk_edge;

  dpfc_delay_cnt #(.CYCLES(`DPFC_RST_OUT_CYC)) u_out_dly (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .o_done(out_ok)); // RULE1
  dpfc_delay_cnt #(.CYCLES(`DPFC_RST_WR_CYC)) u_wr_dly (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .o_done(wr_ok)); // RULE2

  // variant address width: top bit forced low on the small part
  assign amask = i_big_variant ? {`DPFC_ADDR_W{1'b1}} : {1'b0, {(`DPFC_ADDR_W-1){1'b1}}}; // RULE18
  assign wr.addr = i_address_pins & amask;
  assign wr.data = i_data_pins;
  // partitions follow the four planes; plane size halves on the small part
  assign wpart = i_big_variant ? wr.addr[`DPFC_PART_SHIFT+1 -: 2]
                               : wr.addr[`DPFC_PART_SHIFT -: 2]; // RULE23
  // an active burst reads from its own address counter, not the pins
  assign rpart = !burst_on_r ? wpart
               : i_big_variant ? burst_addr_r[`DPFC_PART_SHIFT+1 -: 2]
                               : burst_addr_r[`DPFC_PART_SHIFT -: 2]; // RULE12 RULE23

  // whichever strobe rises first ends the write cycle
  assign wr_edge = (!we_d_r && !cs_d_r) && (i_write_n || i_chip_sel_n); // RULE20
  assign o_standby = i_chip_sel_n; // RULE15
  // a one-time-block program or full erase locks out every other partition
  assign exclusive = busy_r && (act_op_r == DPFC_OP_OTP || act_op_r == DPFC_OP_CHIP_ERASE);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      we_d_r   <= 1'b1;
      cs_d_r   <= 1'b1;
      adv_d_r  <= 1'b1;
      bclk_d_r <= 1'b0;
    end else if (i_ce) begin
      we_d_r   <= i_write_n;
      cs_d_r   <= i_chip_sel_n;
      adv_d_r  <= i_address_valid_n;
      bclk_d_r <= i_burst_clk;
    end
  end

  // command interface decoder
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      cmd_st_r  <= DPFC_S_IDLE;
      pend_op_r <= DPFC_OP_NONE;
      page_cnt_r <= '0;
      page_idx_r <= '0;
      // asynchronous reads and a rising burst edge until configured
      rcr_r     <= 16'hFFFF;
      for (int i = 0; i < 4; i++) rmode_r[i] <= DPFC_RM_ARRAY; // RULE21 RULE22
    end else if (i_ce && wr_edge && wr_ok) begin // RULE2
      unique case (cmd_st_r)
        DPFC_S_IDLE: begin
          unique case (wr.data[7:0])
            `DPFC_CMD_READ_ARRAY:  rmode_r[wpart] <= DPFC_RM_ARRAY;
            `DPFC_CMD_READ_ID:     rmode_r[wpart] <= DPFC_RM_ID;
            `DPFC_CMD_READ_QUERY:  rmode_r[wpart] <= DPFC_RM_QUERY;
            `DPFC_CMD_READ_STATUS: rmode_r[wpart] <= DPFC_RM_STATUS;
            `DPFC_CMD_SET_RCR:     cmd_st_r <= DPFC_S_RCR;
            `DPFC_CMD_WORD_PROG, `DPFC_CMD_OTP_PROG, `DPFC_CMD_BLK_ERASE,
            `DPFC_CMD_CHIP_ERASE, `DPFC_CMD_PAGE_PROG: begin
              // one active operation; a parked erase lets only word and page programs start
              if (!busy_r && !exclusive && !prg_susp_r &&
                  (!ers_susp_r || wr.data[7:0] == `DPFC_CMD_WORD_PROG ||
                   wr.data[7:0] == `DPFC_CMD_PAGE_PROG)) begin // RULE9
                pend_op_r <= (wr.data[7:0] == `DPFC_CMD_WORD_PROG) ? DPFC_OP_WORD :
                             (wr.data[7:0] == `DPFC_CMD_OTP_PROG)  ? DPFC_OP_OTP :
                             (wr.data[7:0] == `DPFC_CMD_BLK_ERASE) ? DPFC_OP_BLK_ERASE :
                             (wr.data[7:0] == `DPFC_CMD_CHIP_ERASE) ? DPFC_OP_CHIP_ERASE :
                             DPFC_OP_PAGE; // RULE3 RULE4
                cmd_st_r <= (wr.data[7:0] == `DPFC_CMD_PAGE_PROG) ? DPFC_S_PAGE_CNT :
                            (wr.data[7:0] == `DPFC_CMD_WORD_PROG ||
                             wr.data[7:0] == `DPFC_CMD_OTP_PROG) ? DPFC_S_SETUP
                                                                 : DPFC_S_CONFIRM;
                rmode_r[wpart] <= DPFC_RM_STATUS;
              end
            end
            default: ;
          endcase
        end
        DPFC_S_SETUP: cmd_st_r <= DPFC_S_IDLE;
        DPFC_S_PAGE_CNT: begin
          page_cnt_r <= wr.data[`DPFC_PAGE_IDX_W-1:0];
          page_idx_r <= '0;
          cmd_st_r   <= DPFC_S_PAGE_DATA;
        end
        DPFC_S_PAGE_DATA: begin
          page_idx_r <= page_idx_r + 1'b1;
          if (page_idx_r == page_cnt_r) cmd_st_r <= DPFC_S_CONFIRM;
        end
        DPFC_S_CONFIRM: cmd_st_r <= DPFC_S_IDLE;
        DPFC_S_RCR: begin
          if (wr.data[7:0] == `DPFC_CMD_RCR_CONFIRM) rcr_r <= wr.addr[15:0];
          cmd_st_r <= DPFC_S_IDLE;
        end
      endcase
    end
  end

  // page buffer: the only data queued ahead of an operation
  // no reset: only words written since the setup are ever handed on
  always_ff @(posedge i_core_clk) begin
    if (i_ce && wr_edge && wr_ok && cmd_st_r == DPFC_S_PAGE_DATA)
      page_buf_r[page_idx_r] <= wr.data; // RULE9 RULE14
  end

  // write state machine with nested suspend
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      busy_r        <= 1'b0;
      act_op_r      <= DPFC_OP_NONE;
      act_part_r    <= 2'h0;
      op_addr_r     <= '0;
      op_data_r     <= 16'h0000;
      ers_susp_r    <= 1'b0;
      prg_susp_r    <= 1'b0;
      ers_part_r    <= 2'h0;
      prg_part_r    <= 2'h0;
      ers_addr_r    <= '0;
      prg_addr_r    <= '0;
      prg_data_r    <= 16'h0000;
      susp_prg_op_r <= DPFC_OP_NONE;
    end else if (i_ce) begin
      // completion wins over a suspend in the same cycle: the operation is over
      if (busy_r && i_array_done) begin
        busy_r <= 1'b0;
      end else if (wr_edge && wr_ok) begin
        if ((cmd_st_r == DPFC_S_SETUP) ||
            (cmd_st_r == DPFC_S_CONFIRM && wr.data[7:0] == `DPFC_CMD_CONFIRM)) begin
          busy_r     <= 1'b1;
          act_op_r   <= pend_op_r;
          act_part_r <= wpart;
          op_addr_r  <= wr.addr; // RULE14
          op_data_r  <= wr.data; // RULE14
        end else if (cmd_st_r == DPFC_S_IDLE && busy_r &&
                     wr.data[7:0] == `DPFC_CMD_SUSPEND) begin // RULE5
          // one-time-block program and full erase cannot park, so they run on
          if (act_op_r == DPFC_OP_BLK_ERASE && !ers_susp_r) begin
            busy_r     <= 1'b0;
            ers_susp_r <= 1'b1;
            ers_part_r <= act_part_r;
            ers_addr_r <= op_addr_r;
          end else if ((act_op_r == DPFC_OP_WORD || act_op_r == DPFC_OP_PAGE) &&
                       !prg_susp_r) begin // RULE6
            busy_r        <= 1'b0;
            prg_susp_r    <= 1'b1;
            prg_part_r    <= act_part_r;
            prg_addr_r    <= op_addr_r;
            prg_data_r    <= op_data_r;
            susp_prg_op_r <= act_op_r;
          end
        end else if (cmd_st_r == DPFC_S_IDLE && !busy_r &&
                     wr.data[7:0] == `DPFC_CMD_RESUME) begin
          // the inner program always resumes before the outer erase
          if (prg_susp_r) begin // RULE6
            prg_susp_r <= 1'b0;
            busy_r     <= 1'b1;
            act_op_r   <= susp_prg_op_r;
            act_part_r <= prg_part_r;
            op_addr_r  <= prg_addr_r;
            op_data_r  <= prg_data_r;
          end else if (ers_susp_r) begin
            ers_susp_r <= 1'b0;
            busy_r     <= 1'b1;
            act_op_r   <= DPFC_OP_BLK_ERASE;
            act_part_r <= ers_part_r;
            op_addr_r  <= ers_addr_r;
          end
        end
      end
    end
  end

  assign o_array_cmd.start = busy_r;
  assign o_array_cmd.op    = act_op_r;
  assign o_array_cmd.part  = act_part_r;
  assign o_array_cmd.addr  = op_addr_r;
  assign o_array_cmd.data  = (act_op_r == DPFC_OP_PAGE) ? page_buf_r[0] : op_data_r;

  always_comb begin
    for (int p = 0; p < 4; p++)
      clr_st[p] = wr_edge && wr_ok && cmd_st_r == DPFC_S_IDLE && wpart == 2'(p) &&
                  wr.data[7:0] == `DPFC_CMD_CLR_STATUS;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_status
      dpfc_status u_status (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_ce       (i_ce),
        .i_busy     (busy_r && act_part_r == 2'(g)),
        .i_prg_susp (prg_susp_r && prg_part_r == 2'(g)),
        .i_ers_susp (ers_susp_r && ers_part_r == 2'(g)),
        .i_clear    (clr_st[g]),
        .o_status   (status[g])); // RULE10
    end
  endgenerate

  // burst address capture on the configured clock edge or on a rising address valid, only in sync mode
  assign bclk_edge = rcr_r[`DPFC_RCR_CLK_EDGE] ? (i_burst_clk && !bclk_d_r)
                                               : (!i_burst_clk && bclk_d_r); // RULE16
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      burst_addr_r <= '0;
      burst_on_r   <= 1'b0;
    end else if (i_ce) begin
      if (i_chip_sel_n || rcr_r[`DPFC_RCR_SYNC_N]) begin // RULE17
        burst_on_r <= 1'b0;
      end else if ((!i_address_valid_n && bclk_edge) || (i_address_valid_n && !adv_d_r)) begin
        burst_addr_r <= wr.addr; // RULE16
        burst_on_r   <= 1'b1;
      end else if (bclk_edge && burst_on_r) begin
        // stop at the partition boundary; host restarts the burst
        if (i_big_variant ? &burst_addr_r[`DPFC_PART_SHIFT-1:0]
                          : &burst_addr_r[`DPFC_PART_SHIFT-2:0]) burst_on_r <= 1'b0; // RULE12
        else burst_addr_r <= burst_addr_r + 1'b1;
      end
    end
  end

  // read data path
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_data_pins <= 16'h0000;
      o_data_oe   <= 1'b0;
    end else if (i_ce) begin
      o_data_oe <= out_ok && !i_chip_sel_n && !i_out_gate_n && i_write_n; // RULE1 RULE13
      // the running partition, and all others during an exclusive op, read status
      if (exclusive && rpart != act_part_r) begin
        o_data_pins <= {8'h00, status[rpart]}; // RULE8
      end else if (busy_r && rpart == act_part_r) begin
        o_data_pins <= {8'h00, status[rpart]};
      end else begin
        unique case (rmode_r[rpart]) // RULE7 RULE19
          DPFC_RM_ARRAY:  o_data_pins <= i_array_rdata;
          DPFC_RM_STATUS: o_data_pins <= {8'h00, status[rpart]};
          DPFC_RM_ID:     o_data_pins <= i_array_rdata;
          DPFC_RM_QUERY:  o_data_pins <= i_array_rdata;
          default:        o_data_pins <= i_array_rdata;
        endcase
      end
    end
  end
endmodule // dpfc_flash_ctrl

/* dpfc_flash_ctrl_monitor.sv */
`timescale 1ns/1ps
`include "dpfc_defines.svh"
module dpfc_flash_ctrl_monitor
  import dpfc_pkg::*;
(
  // clock and reset
  input wire logic                    i_core_clk,
  input wire logic                    i_rst_b,
  input wire logic                    i_ce,
  // bus pins
  input wire logic                    i_chip_sel_n,
  input wire logic                    i_out_gate_n,
  input wire logic                    i_write_n,
  input wire logic                    i_address_valid_n,
  input wire logic                    i_burst_clk,
  input wire logic                    i_big_variant,
  input wire logic [`DPFC_ADDR_W-1:0] i_address_pins,
  input wire logic [15:0]             i_data_pins,
  input wire logic [15:0]             o_data_pins,
  input wire logic                    o_data_oe,
  // array side
  input wire dpfc_pkg::dpfc_array_cmd_t o_array_cmd,
  input wire logic [15:0]             i_array_rdata,
  input wire logic                    i_array_done,
  input wire logic                    o_standby
);
  localparam int RST_OUT = `DPFC_RST_OUT_CYC;
  localparam int RST_WR  = `DPFC_RST_WR_CYC;
  logic [7:0] cnt_r;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) cnt_r <= 8'h00;
    else if (cnt_r != 8'hFF) cnt_r <= cnt_r + 8'h01;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  property p_rst_vals;
    disable iff (1'b0) !i_rst_b |=> !o_data_oe && !o_array_cmd.start && o_data_pins == 16'h0000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("outputs not cleared by reset");
  // two cycles of slack for the registered enable
  property p_rst_out; (cnt_r < RST_OUT - 2) |-> !o_data_oe; endproperty
  a_rst_out: assert property (p_rst_out) else $error("output drive before recovery");
  property p_wake; $rose(o_array_cmd.start) |-> cnt_r > RST_WR; endproperty
  a_wake: assert property (p_wake) else $error("command acted on before wake");
  property p_float; o_data_oe |-> !$past(i_chip_sel_n) && !$past(i_out_gate_n); endproperty
  a_float: assert property (p_float) else $error("data pins driven while not gated");
  property p_standby; o_standby == i_chip_sel_n; endproperty
  a_standby: assert property (p_standby) else $error("standby not following select");
  property p_hold;
    o_array_cmd.start && !i_array_done && i_write_n && $past(i_write_n) && $past(i_write_n, 2)
      |=> o_array_cmd.start;
  endproperty
  a_hold: assert property (p_hold) else $error("operation dropped without cause");
  property p_op_stable;
    o_array_cmd.start && $past(o_array_cmd.start) |-> $stable(o_array_cmd.op) &&
      $stable(o_array_cmd.part);
  endproperty
  a_op_stable: assert property (p_op_stable) else $error("operation changed while busy");
  property p_part;
    $rose(o_array_cmd.start) |-> o_array_cmd.part == (i_big_variant ? o_array_cmd.addr[21:20]
      : o_array_cmd.addr[20:19]);
  endproperty
  a_part: assert property (p_part) else $error("partition not from upper address");
  property p_cause;
    $rose(o_array_cmd.start) |-> !$past(i_write_n, 2) || !$past(i_write_n, 3) ||
      !$past(i_write_n, 4);
  endproperty
  a_cause: assert property (p_cause) else $error("operation started with no write");
  c_chip: cover property ($rose(o_array_cmd.start) && o_array_cmd.op == DPFC_OP_CHIP_ERASE);
  c_susp: cover property ($fell(o_array_cmd.start) && !$past(i_array_done));
  c_read: cover property ($rose(o_data_oe));
endmodule // dpfc_flash_ctrl_monitor
bind dpfc_flash_ctrl dpfc_flash_ctrl_monitor u_mon (.i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b), .i_ce(i_ce), .i_chip_sel_n(i_chip_sel_n), .i_out_gate_n(i_out_gate_n),
  .i_write_n(i_write_n), .i_address_valid_n(i_address_valid_n), .i_burst_clk(i_burst_clk),
  .i_big_variant(i_big_variant), .i_address_pins(i_address_pins), .i_data_pins(i_data_pins),
  .o_data_pins(o_data_pins), .o_data_oe(o_data_oe), .o_array_cmd(o_array_cmd),
  .i_array_rdata(i_array_rdata), .i_array_done(i_array_done), .o_standby(o_standby));

/* dpfc_pkg.sv */
`include "dpfc_defines.svh"
package dpfc_pkg;
  typedef enum logic [2:0] {
    DPFC_RM_ARRAY, DPFC_RM_STATUS, DPFC_RM_ID, DPFC_RM_QUERY
  } dpfc_rmode_t;
  typedef enum logic [2:0] {
    DPFC_OP_NONE, DPFC_OP_WORD, DPFC_OP_PAGE, DPFC_OP_OTP,
    DPFC_OP_BLK_ERASE, DPFC_OP_CHIP_ERASE
  } dpfc_op_t;
  typedef struct packed {
    logic [`DPFC_ADDR_W-1:0] addr;
    logic [15:0]             data;
  } dpfc_wr_t;
  typedef struct packed {
    logic                    start;
    dpfc_op_t                op;
    logic [1:0]              part;
    logic [`DPFC_ADDR_W-1:0] addr;
    logic [15:0]             data;
  } dpfc_array_cmd_t;
endpackage

/* dpfc_status.sv */
`timescale 1ns/1ps
`include "dpfc_defines.svh"
// per-partition status register; hardware set wins over clear
module dpfc_status (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_ce,
  // controls
  input  wire logic       i_busy,
  input  wire logic       i_prg_susp,
  input  wire logic       i_ers_susp,
  input  wire logic       i_clear,
  // status
  output logic [7:0]      o_status
);
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_status <= `DPFC_STATUS_RESET; // RULE22
    end else if (i_ce) begin
      o_status[`DPFC_SR_READY]    <= !i_busy; // RULE10
      o_status[`DPFC_SR_ERS_SUSP] <= i_ers_susp;
      o_status[`DPFC_SR_PRG_SUSP] <= i_prg_susp;
      if (i_clear) begin
        o_status[5:3] <= 3'h0;
        o_status[1:0] <= 2'h0;
      end
    end
  end
endmodule // dpfc_status

/* tb_dual_partition_flash_control.sv */
`timescale 1ns/1ps
`include "dpfc_defines.svh"
module tb_dual_partition_flash_control;
  import dpfc_pkg::*;
  localparam logic [15:0] RD = 16'h5A3C;
  logic                    i_core_clk = 1'b0;
  logic                    i_rst_b    = 1'b0;
  logic                    cs_n = 1'b1, og_n = 1'b1, we_n = 1'b1, adv_n = 1'b1;
  logic                    bclk = 1'b0, hold = 1'b0, oe, done, standby;
  logic                    ce = 1'b1, big = 1'b1;
  logic [`DPFC_ADDR_W-1:0] addr = '0;
  logic [15:0]             din = 16'h0000, rdata, dout;
  dpfc_array_cmd_t         cmd;
  int                      err_count = 0, checked = 0;
  always #4 i_core_clk = ~i_core_clk;
  // burst clock toggles freely; asynchronous mode must ignore it
  always @(negedge i_core_clk) bclk <= 1'($urandom_range(1));
  dpfc_flash_ctrl dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(ce),
    .i_chip_sel_n(cs_n), .i_out_gate_n(og_n), .i_write_n(we_n), .i_address_valid_n(adv_n),
    .i_burst_clk(bclk), .i_big_variant(big), .i_address_pins(addr), .i_data_pins(din),
    .o_data_pins(dout), .o_data_oe(oe), .o_array_cmd(cmd), .i_array_rdata(rdata),
    .i_array_done(done), .o_standby(standby));
  dpfc_array_model #(.DELAY(3), .RDATA(RD)) u_array (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_cmd(cmd), .i_hold(hold), .o_rdata(rdata), .o_done(done));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [7:0] stat(input logic busy, input logic es, input logic ps);
    return {~busy, es, 3'b000, ps, 2'b00};
  endfunction
  // strobe rises first; values changed while select is still low must be ignored
  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    addr = a; din = d; cs_n = 1'b0; we_n = 1'b0; adv_n = 1'b0;
    repeat (2) @(negedge i_core_clk);
    we_n = 1'b1;
    @(negedge i_core_clk);
    addr = ~a; din = ~d;
    @(negedge i_core_clk);
    cs_n = 1'b1; adv_n = 1'b1;
    repeat (2) @(negedge i_core_clk);
  endtask
  task automatic rd(input logic [21:0] a, output logic [15:0] d);
    @(negedge i_core_clk);
    addr = a; cs_n = 1'b0; og_n = 1'b0; adv_n = 1'b0;
    repeat (3) @(negedge i_core_clk);
    chk("read drive", oe, 1'b1);
    d = dout;
    og_n = 1'b1;
    repeat (2) @(negedge i_core_clk);
    chk("ungated float", oe, 1'b0);
    cs_n = 1'b1; adv_n = 1'b1;
    @(negedge i_core_clk);
    chk("standby", standby, 1'b1);
  endtask
  task automatic rstat(input logic [21:0] a, input logic [7:0] exp);
    logic [15:0] d;
    wr(a, 16'h0070);
    rd(a, d);
    chk("status", d[7:0], exp);
  endtask
  task automatic rarr(input logic [21:0] a);
    logic [15:0] d;
    wr(a, 16'h00FF);
    rd(a, d);
    chk("array read", d, RD);
  endtask
  task automatic wait_start(input logic lvl);
    int n;
    n = 0;
    while (cmd.start !== lvl && n < 100) begin
      @(negedge i_core_clk);
      n++;
    end
    chk("start", cmd.start, lvl);
    if (cmd.start !== lvl) end_of_test();
  endtask
  task automatic go(input logic [21:0] a, input logic [15:0] c, input logic [15:0] d,
                    input dpfc_op_t op);
    wr(a, c);
    wr(a, d);
    wait_start(1'b1);
    chk("op", cmd.op, op);
    chk("part", cmd.part, big ? a[21:20] : a[20:19]);
    chk("masked addr", cmd.addr, big ? a : {1'b0, a[20:0]});
  endtask
  initial begin
    logic [21:0] a, b;
    logic [15:0] d, v;
    void'($urandom(32'h8EF6ED12));
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst_b = 1'b1;
    wr(22'h000100, 16'h0040);
    wr(22'h000100, 16'h1234);
    chk("early command", cmd.start, 1'b0);
    repeat (8) @(negedge i_core_clk);
    for (int p = 0; p < 4; p++) begin
      rd({2'(p), 20'h00000}, d);
      chk("reset mode", d, RD);
      rstat({2'(p), 20'h00000}, 8'h80);
    end
    for (int i = 0; i < 4; i++) begin
      a = 22'($urandom());
      b = a ^ 22'h100000;
      v = 16'($urandom());
      hold = 1'b1;
      go(a, 16'h0040, v, DPFC_OP_WORD);
      chk("latched data", cmd.data, v);
      chk("latched addr", cmd.addr, a);
      rstat(a, stat(1'b1, 1'b0, 1'b0));
      rstat(b, 8'h80);
      rarr(b);
      wr(b, 16'h0040);
      wr(b, 16'h5555);
      chk("refused part", cmd.part, a[21:20]);
      hold = 1'b0;
      wait_start(1'b0);
      rstat(a, 8'h80);
    end
    a = 22'h008000;
    b = 22'h200000;
    hold = 1'b1;
    go(a, 16'h0020, 16'h00D0, DPFC_OP_BLK_ERASE);
    wr(a, 16'h00B0);
    wait_start(1'b0);
    rstat(a, stat(1'b0, 1'b1, 1'b0));
    rarr(22'h010000);
    go(b, 16'h0040, 16'hBEEF, DPFC_OP_WORD);
    wr(b, 16'h00B0);
    wait_start(1'b0);
    rstat(b, stat(1'b0, 1'b0, 1'b1));
    rarr(b + 22'h000040);
    wr(b, 16'h00D0);
    wait_start(1'b1);
    chk("resume program", cmd.op, DPFC_OP_WORD);
    hold = 1'b0;
    wait_start(1'b0);
    hold = 1'b1;
    wr(a, 16'h00D0);
    wait_start(1'b1);
    chk("resume erase", cmd.op, DPFC_OP_BLK_ERASE);
    hold = 1'b0;
    wait_start(1'b0);
    for (int i = 0; i < 2; i++) begin
      hold = 1'b1;
      if (i == 0) go(22'h000040, 16'h0030, 16'h00D0, DPFC_OP_CHIP_ERASE);
      else go(22'h000040, 16'h00C0, 16'h0F0F, DPFC_OP_OTP);
      wr(b, 16'h00FF);
      rd(b, d);
      chk("exclusive read", d == RD, 1'b0);
      wr(b, 16'h0040);
      wr(b, 16'h1111);
      chk("exclusive part", cmd.part, 2'b00);
      hold = 1'b0;
      wait_start(1'b0);
    end
    a = 22'h300080;
    wr(a, 16'h00E8);
    wr(a, 16'(`DPFC_PAGE_WORDS - 1));
    v = 16'($urandom());
    wr(a, v);
    for (int i = 1; i < `DPFC_PAGE_WORDS; i++) wr(a + 22'(i), 16'($urandom()));
    hold = 1'b1;
    wr(a, 16'h00D0);
    wait_start(1'b1);
    chk("page op", cmd.op, DPFC_OP_PAGE);
    chk("page data", cmd.data, v);
    hold = 1'b0;
    ce = 1'b0;
    repeat (8) @(negedge i_core_clk);
    chk("frozen", cmd.start, 1'b1);
    ce = 1'b1;
    wait_start(1'b0);
    big = 1'b0;
    hold = 1'b1;
    go(22'h280000, 16'h0040, 16'h2222, DPFC_OP_WORD);
    hold = 1'b0;
    wait_start(1'b0);
    end_of_test();
  end
endmodule // tb_dual_partition_flash_control
